// ---- src/bid_alu.sv ----
// Combinational 8-bit ALU for the decoder core.
// Assumes the core masks flag updates for ops that must leave flags alone.
`timescale 1ns/1ps
`default_nettype none
module bid_alu (
  bid_alu_if.alu bus
);
  import bid_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum        = 9'h000;
    nib        = 5'h00;
    bus.res    = bus.a;
    bus.c      = bus.cin;
    bus.dc     = 1'b0;
    bus.upd_c  = 1'b0;
    bus.upd_dc = 1'b0;
    bus.upd_z  = 1'b1;
    case (bus.op)
      OP_ADD: begin
        sum        = {1'b0, bus.a} + {1'b0, bus.w};
        nib        = {1'b0, bus.a[3:0]} + {1'b0, bus.w[3:0]};
        bus.res    = sum[7:0];
        bus.c      = sum[8];
        bus.dc     = nib[4];
        bus.upd_c  = 1'b1;
        bus.upd_dc = 1'b1;
      end
      OP_SUB: begin
        sum        = {1'b0, bus.a} + {1'b0, ~bus.w} + 9'h001;
        nib        = {1'b0, bus.a[3:0]} + {1'b0, ~bus.w[3:0]} + 5'h01;
        bus.res    = sum[7:0];
        bus.c      = sum[8];
        bus.dc     = nib[4];
        bus.upd_c  = 1'b1;
        bus.upd_dc = 1'b1;
      end
      OP_AND:  bus.res = bus.a & bus.w;
      OP_OR:   bus.res = bus.a | bus.w;
      OP_XOR:  bus.res = bus.a ^ bus.w;
      OP_COM:  bus.res = ~bus.a;
      OP_DEC:  bus.res = bus.a - 8'h01;
      OP_INC:  bus.res = bus.a + 8'h01;
      OP_CLR:  bus.res = 8'h00;
      OP_RL: begin
        bus.res   = {bus.a[6:0], bus.cin};
        bus.c     = bus.a[7];
        bus.upd_c = 1'b1;
        bus.upd_z = 1'b0;
      end
      OP_RR: begin
        bus.res   = {bus.cin, bus.a[7:1]};
        bus.c     = bus.a[0];
        bus.upd_c = 1'b1;
        bus.upd_z = 1'b0;
      end
      OP_SWAP: begin
        bus.res   = {bus.a[3:0], bus.a[7:4]};
        bus.upd_z = 1'b0;
      end
      OP_PASSW: begin
        bus.res   = bus.w;
        bus.upd_z = 1'b0;
      end
      OP_BCLR: begin
        bus.res           = bus.a;
        bus.res[bus.bsel] = 1'b0;
        bus.upd_z         = 1'b0;
      end
      OP_BSET: begin
        bus.res           = bus.a;
        bus.res[bus.bsel] = 1'b1;
        bus.upd_z         = 1'b0;
      end
      default: bus.res = bus.a;
    endcase
  end
endmodule : bid_alu
`default_nettype wire

// ---- src/bid_alu_if.sv ----
// Operand and result bundle between the decoder core and its ALU.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface bid_alu_if;
  import bid_pkg::*;
  bid_op_t    op;
  logic [7:0] a;
  logic [7:0] w;
  logic [2:0] bsel;
  logic       cin;
  logic [7:0] res;
  logic       c;
  logic       dc;
  logic       upd_c;
  logic       upd_dc;
  logic       upd_z;
  modport core (output op, a, w, bsel, cin, input res, c, dc, upd_c, upd_dc, upd_z);
  modport alu  (input op, a, w, bsel, cin, output res, c, dc, upd_c, upd_dc, upd_z);
endinterface : bid_alu_if
`default_nettype wire

// ---- src/bid_core.sv ----
// Instruction decoder and execute control for a 12-bit-word accumulator core.
// Assumes program memory and file registers answer within one clock.
//
// How it works
// - Add and subtract use accumulator and register, updating carry, digit carry, zero.
// - Destination bit 0 writes accumulator, 1 writes the addressed register.
// - AND, OR, XOR with accumulator and complement update only zero.
// - Rotate left or right through carry, updating only carry.
// - Decrement/increment-and-skip store result, keep flags, skip on zero.
// - Bit tests skip next instruction on clear or set bit, flags untouched.
// - Bit clear and bit set force one register bit, flags untouched.
// - Literal AND, OR, XOR set zero; literal load keeps flags.
// - Return-with-literal loads accumulator, pops return address, takes two cycles.
// - Standby instruction enters sleep and updates time-out and power-down bits.
// - Program counter writes other than branch and return clear counter bit 8.
// - Port register operands come from pin levels, not output latches.
// - Direction load with operand 6 copies accumulator to port direction latches.
// - Timer register writes clear prescaler when prescaler belongs to timer.
// - One instruction cycle is four clocks; skips and jumps take two.
// - A taken skip replaces the fetched instruction by a no-operation.
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module bid_core #(
  parameter logic [8:0] RESET_VEC = 9'h000
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic [3:0]    avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [31:0]   avs_writedata_in,
  output logic      [31:0]   avs_readdata_out,
  output logic               avs_waitrequest_out,
  output logic      [8:0]    pmem_addr_out,
  input  wire logic [11:0]   pmem_data_in,
  output logic      [4:0]    freg_raddr_out,
  input  wire logic [7:0]    freg_rdata_in,
  output logic      [4:0]    freg_waddr_out,
  output logic      [7:0]    freg_wdata_out,
  output logic               freg_we_out,
  input  wire logic [7:0]    port_pin_in,
  output logic      [7:0]    direction_latch_load_out,
  output logic      [7:0]    option_out,
  output logic               presc_clr_out,
  output logic               wdt_clr_out,
  input  wire logic          wake_in
);
  import bid_pkg::*;

  // ****************************************
  // State
  // ****************************************
  bid_phase_t            phase_ff, nxt_phase;
  logic [PC_W-1:0]       pc_ff, nxt_pc;
  logic [PC_W-1:0]       stk0_ff, nxt_stk0;
  logic [PC_W-1:0]       stk1_ff, nxt_stk1;
  logic [11:0]           ir_ff, nxt_ir;
  logic [7:0]            acc_ff, nxt_acc;
  logic [5:0]            stat_ff, nxt_stat;
  logic [7:0]            direction_latch_load_ff, nxt_direction_latch_load;
  logic [7:0]            opt_ff, nxt_opt;
  logic [4:0]            waddr_ff, nxt_waddr;
  logic [7:0]            wdata_ff, nxt_wdata;
  logic                  we_ff, nxt_we;
  logic                  pclr_ff, nxt_pclr;
  logic                  wclr_ff, nxt_wclr;

  bid_op_t     op;
  logic        use_lit;
  logic        wr_w;
  logic        wr_f;
  logic        noflag;
  logic        skz;
  logic        btc;
  logic        bts;
  logic        is_branch_op;
  logic        is_call;
  logic        is_ret;
  logic        is_opt;
  logic        is_sleep;
  logic        is_wdt;
  logic        is_direction_latch_load;
  logic        run;
  logic        commit;
  logic        skip;
  logic        bit_val;
  logic [7:0]  opnd;
  logic [4:0]  fa;
  logic        d_bit;

  bid_alu_if alu_bus ();

  bid_alu u_alu (
    .bus (alu_bus.alu)
  );

  bid_csr u_csr (
    .clk_in              (clk_in),
    .rst_n_in            (rst_n_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .stat_in             (stat_ff),
    .pc_in               (pc_ff),
    .ir_in               (ir_ff),
    .acc_in              (acc_ff),
    .run_out             (run)
  );

  assign fa    = ir_ff[4:0];
  assign d_bit = ir_ff[5];

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    op = OP_PASSA; use_lit = 1'b0; wr_w = 1'b0; wr_f = 1'b0;
    noflag = 1'b0; skz = 1'b0; btc = 1'b0; bts = 1'b0;
    is_branch_op = 1'b0; is_call = 1'b0; is_ret = 1'b0; is_opt = 1'b0;
    is_sleep = 1'b0; is_wdt = 1'b0; is_direction_latch_load = 1'b0;
    case (ir_ff[11:10])
      2'b00: begin
        wr_w = ~d_bit;
        wr_f = d_bit;
        case (ir_ff[9:6])
          4'h0: begin
            op   = OP_PASSW;
            wr_w = 1'b0;
            if (!d_bit) begin
              case (fa)
                MISC_OPTION: is_opt   = 1'b1;
                MISC_SLEEP:  is_sleep = 1'b1;
                MISC_WDT:    is_wdt   = 1'b1;
                5'h05, 5'h06, 5'h07: is_direction_latch_load = 1'b1;
                default: ;
              endcase
            end
          end
          4'h1: op = OP_CLR;
          4'h2: op = OP_SUB;
          4'h3: op = OP_DEC;
          4'h4: op = OP_OR;
          4'h5: op = OP_AND;
          4'h6: op = OP_XOR;
          4'h7: op = OP_ADD;
          4'h8: op = OP_PASSA;
          4'h9: op = OP_COM;
          4'ha: op = OP_INC;
          4'hb: begin
            op = OP_DEC; noflag = 1'b1; skz = 1'b1;
          end
          4'hc: op = OP_RR;
          4'hd: op = OP_RL;
          4'he: op = OP_SWAP;
          4'hf: begin
            op = OP_INC; noflag = 1'b1; skz = 1'b1;
          end
          default: ;
        endcase
      end
      2'b01: begin
        // bit ops, bit force; neither touches a flag
        noflag = 1'b1;
        wr_f   = ~ir_ff[9];
        case (ir_ff[9:8])
          2'b00: op = OP_BCLR;
          2'b01: op = OP_BSET;
          2'b10: btc = 1'b1;
          default: bts = 1'b1;
        endcase
      end
      2'b10: begin
        use_lit = 1'b1;
        noflag  = 1'b1;
        is_branch_op = ir_ff[9];
        is_call = ~ir_ff[9] & ir_ff[8];
        is_ret  = ~ir_ff[9] & ~ir_ff[8];
        wr_w    = ~ir_ff[9] & ~ir_ff[8];
      end
      default: begin
        use_lit = 1'b1;
        wr_w    = 1'b1;
        case (ir_ff[9:8])
          2'b00: noflag = 1'b1;
          2'b01: op = OP_OR;
          2'b10: op = OP_AND;
          default: op = OP_XOR;
        endcase
      end
    endcase
  end

  // ****************************************
  // Operands and skip
  // ****************************************
  // pin levels for port
  assign opnd = use_lit ? ir_ff[7:0] : (fa == FA_PCL) ? pc_ff[7:0] :
                (fa == FA_PORT_B_REGISTER) ? port_pin_in : freg_rdata_in;

  assign alu_bus.op   = op;
  assign alu_bus.a    = opnd;
  assign alu_bus.w    = acc_ff;
  assign alu_bus.bsel = ir_ff[7:5];
  assign alu_bus.cin  = stat_ff[ST_C];
  assign bit_val      = opnd[ir_ff[7:5]];
  assign skip   = (skz & (alu_bus.res == 8'h00)) | (btc & ~bit_val) | (bts & bit_val);
  assign commit = (phase_ff == PH_Q4) & run & ~stat_ff[ST_SLEEP];

  assign pmem_addr_out  = pc_ff;
  assign freg_raddr_out = fa;
  assign freg_waddr_out = waddr_ff;
  assign freg_wdata_out = wdata_ff;
  assign freg_we_out    = we_ff;
  assign direction_latch_load_out       = direction_latch_load_ff;
  assign option_out     = opt_ff;
  assign presc_clr_out  = pclr_ff;
  assign wdt_clr_out    = wclr_ff;

  // ****************************************
  // Execute
  // ****************************************
  always_comb begin
    nxt_phase = (phase_ff == PH_Q4) ? PH_Q1 : bid_phase_t'(phase_ff + 2'b01);
    nxt_pc = pc_ff; nxt_stk0 = stk0_ff; nxt_stk1 = stk1_ff; nxt_ir = ir_ff;
    nxt_acc = acc_ff; nxt_stat = stat_ff; nxt_direction_latch_load = direction_latch_load_ff; nxt_opt = opt_ff;
    nxt_waddr = waddr_ff; nxt_wdata = wdata_ff;
    nxt_we = 1'b0; nxt_pclr = 1'b0; nxt_wclr = 1'b0;
    if (stat_ff[ST_SLEEP] && wake_in) nxt_stat[ST_SLEEP] = 1'b0;
    if (commit) begin
      nxt_ir = pmem_data_in;
      nxt_pc = pc_ff + 9'h001;
      if (wr_w) nxt_acc = alu_bus.res;
      if (!noflag) begin
        if (alu_bus.upd_c)  nxt_stat[ST_C]  = alu_bus.c;
        if (alu_bus.upd_dc) nxt_stat[ST_DC] = alu_bus.dc;
        if (alu_bus.upd_z)  nxt_stat[ST_Z]  = (alu_bus.res == 8'h00);
      end
      if (wr_f) begin
        nxt_we    = 1'b1;
        nxt_waddr = fa;
        nxt_wdata = alu_bus.res;
        nxt_pclr  = (fa == FA_TIMER) & ~opt_ff[OPT_PSA_BIT];
      end
      if (skip) nxt_ir = INSN_NOP;
      if (is_branch_op) begin
        nxt_pc = ir_ff[8:0];
        nxt_ir = INSN_NOP;
      end
      if (is_call) begin
        nxt_stk1 = stk0_ff;
        nxt_stk0 = pc_ff;
        nxt_pc   = {1'b0, ir_ff[7:0]};
        nxt_ir   = INSN_NOP;
      end
      if (is_ret) begin
        nxt_pc   = stk0_ff;
        nxt_stk0 = stk1_ff;
        nxt_ir   = INSN_NOP;
      end
      if (wr_f && fa == FA_PCL) begin
        nxt_pc = {1'b0, alu_bus.res};
        nxt_ir = INSN_NOP;
      end
      if (is_sleep) begin
        nxt_stat[ST_SLEEP] = 1'b1;
        nxt_stat[ST_TO]    = 1'b1;
        nxt_stat[ST_PD]    = 1'b0;
      end
      if (is_wdt) begin
        nxt_stat[ST_TO] = 1'b1;
        nxt_stat[ST_PD] = 1'b1;
        nxt_wclr        = 1'b1;
      end
      if (is_opt) nxt_opt = acc_ff;
      if (is_direction_latch_load && fa == FA_PORT_B_REGISTER) nxt_direction_latch_load = acc_ff;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_ff <= PH_Q1;
      pc_ff    <= RESET_VEC;
      stk0_ff  <= 9'h000;
      stk1_ff  <= 9'h000;
      ir_ff    <= INSN_NOP;
      acc_ff   <= 8'h00;
      stat_ff  <= ST_RST;
      direction_latch_load_ff  <= DIRECTION_LATCH_LOAD_RST;
      opt_ff   <= OPTION_RST;
      waddr_ff <= 5'h00;
      wdata_ff <= 8'h00;
      we_ff    <= 1'b0;
      pclr_ff  <= 1'b0;
      wclr_ff  <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      pc_ff    <= nxt_pc;
      stk0_ff  <= nxt_stk0;
      stk1_ff  <= nxt_stk1;
      ir_ff    <= nxt_ir;
      acc_ff   <= nxt_acc;
      stat_ff  <= nxt_stat;
      direction_latch_load_ff  <= nxt_direction_latch_load;
      opt_ff   <= nxt_opt;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      we_ff    <= nxt_we;
      pclr_ff  <= nxt_pclr;
      wclr_ff  <= nxt_wclr;
    end
  end
endmodule : bid_core
`default_nettype wire

// ---- src/bid_csr.sv ----
// Avalon-MM slave with control and status words for the decoder core.
// Assumes a well-behaved master that holds its request under waitrequest.
`timescale 1ns/1ps
`default_nettype none
module bid_csr (
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  input  wire logic [3:0]     avs_address_in,
  input  wire logic           avs_read_in,
  input  wire logic           avs_write_in,
  input  wire logic [31:0]    avs_writedata_in,
  output logic      [31:0]    avs_readdata_out,
  output logic                avs_waitrequest_out,
  input  wire logic [5:0]     stat_in,
  input  wire logic [8:0]     pc_in,
  input  wire logic [11:0]    ir_in,
  input  wire logic [7:0]     acc_in,
  output logic                run_out
);
  import bid_pkg::*;

  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        ack_ff, nxt_ack;
  logic        req;

  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_ff;
  assign avs_readdata_out    = rdata_ff;
  assign run_out             = ctrl_ff[CTRL_RUN];

  always_comb begin
    nxt_ack   = req & ~ack_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = rdata_ff;
    if (avs_write_in && ack_ff && avs_address_in == CSR_CTRL) begin
      nxt_ctrl = {31'h0000_0000, avs_writedata_in[CTRL_RUN]};
    end
    if (avs_read_in && !ack_ff) begin
      case (avs_address_in)
        CSR_CTRL: nxt_rdata = ctrl_ff;
        CSR_STAT: nxt_rdata = {26'h000_0000, stat_in};
        CSR_PCIR: nxt_rdata = {4'h0, ir_in, 7'h00, pc_in};
        CSR_ACC:  nxt_rdata = {24'h00_0000, acc_in};
        default:  nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_ff  <= CTRL_RST;
      rdata_ff <= 32'h0000_0000;
      ack_ff   <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
    end
  end
endmodule : bid_csr
`default_nettype wire

// ---- src/bid_pkg.sv ----
// Constants and types shared by the instruction decoder files.
// Assumes a 12-bit instruction word and an 8-bit file register space.
package bid_pkg;

  // ****************************************
  // Timing and widths
  // ****************************************
  localparam int          PC_W       = 9;
  localparam logic [11:0] INSN_NOP   = 12'h000;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } bid_phase_t;

  typedef enum logic [3:0] {
    OP_PASSA = 4'h0,
    OP_PASSW = 4'h1,
    OP_ADD   = 4'h2,
    OP_SUB   = 4'h3,
    OP_AND   = 4'h4,
    OP_OR    = 4'h5,
    OP_XOR   = 4'h6,
    OP_COM   = 4'h7,
    OP_RL    = 4'h8,
    OP_RR    = 4'h9,
    OP_DEC   = 4'ha,
    OP_INC   = 4'hb,
    OP_SWAP  = 4'hc,
    OP_CLR   = 4'hd,
    OP_BCLR  = 4'he,
    OP_BSET  = 4'hf
  } bid_op_t;

  // ****************************************
  // File addresses and control encodings
  // ****************************************
  localparam logic [4:0] FA_TIMER    = 5'h01;
  localparam logic [4:0] FA_PCL      = 5'h02;
  localparam logic [4:0] FA_PORT_B_REGISTER    = 5'h06;
  localparam logic [4:0] MISC_OPTION = 5'h02;
  localparam logic [4:0] MISC_SLEEP  = 5'h03;
  localparam logic [4:0] MISC_WDT    = 5'h04;
  localparam logic [7:0] OPTION_RST  = 8'hff;
  localparam logic [7:0] DIRECTION_LATCH_LOAD_RST    = 8'hff;
  localparam int         OPT_PSA_BIT = 3;

  // ****************************************
  // Status layout and bus registers
  // ****************************************
  localparam int          ST_C       = 0;
  localparam int          ST_DC      = 1;
  localparam int          ST_Z       = 2;
  localparam int          ST_PD      = 3;
  localparam int          ST_TO      = 4;
  localparam int          ST_SLEEP   = 5;
  localparam logic [5:0]  ST_RST     = 6'h18;
  localparam logic [3:0]  CSR_CTRL   = 4'h0;
  localparam logic [3:0]  CSR_STAT   = 4'h4;
  localparam logic [3:0]  CSR_PCIR   = 4'h8;
  localparam logic [3:0]  CSR_ACC    = 4'hc;
  localparam int          CTRL_RUN   = 0;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;

endpackage : bid_pkg

// ---- verification/bid_core_asserts.sv ----
// Port checker for the decoder core.
// Assumes one clock domain; bound onto bid_core below.
`timescale 1ns/1ps
`default_nettype none
module bid_core_asserts
  import bid_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic [8:0] pmem_addr_out,
  input wire logic       freg_we_out,
  input wire logic [4:0] freg_waddr_out,
  input wire logic [7:0] option_out,
  input wire logic       presc_clr_out,
  input wire logic       wdt_clr_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_req_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_timer_wr;
    freg_we_out && freg_waddr_out == FA_TIMER && !option_out[OPT_PSA_BIT];
  endsequence
  sequence s_quiet3;
    (!freg_we_out)[*3];
  endsequence
  chk_we_spacing: assert property (freg_we_out |=> s_quiet3)
    else $error("file writes closer than four clocks");
  chk_we_commit: assert property (freg_we_out |-> $changed(pmem_addr_out))
    else $error("file write without an instruction commit");
  chk_pc_stands: assert property ($changed(pmem_addr_out) |=> $stable(pmem_addr_out)[*3])
    else $error("fetch address held under four clocks");
  chk_presc_cause: assert property (presc_clr_out |-> s_timer_wr)
    else $error("prescaler clear without a timer write");
  chk_presc_when: assert property (s_timer_wr |-> presc_clr_out)
    else $error("timer write did not clear prescaler");
  chk_wdt_spacing: assert property (wdt_clr_out |=> (!wdt_clr_out)[*3])
    else $error("watchdog clear pulses too close");
  chk_wdt_alone: assert property (wdt_clr_out |-> !freg_we_out && !presc_clr_out)
    else $error("watchdog clear wrote a file register");
  chk_bus_first: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("new bus request not stalled");
  chk_bus_one: assert property (s_req_wait |=> !avs_waitrequest_out)
    else $error("bus request stalled more than one cycle");
endmodule : bid_core_asserts
bind bid_core bid_core_asserts chk_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .pmem_addr_out(pmem_addr_out), .freg_we_out(freg_we_out),
  .freg_waddr_out(freg_waddr_out), .option_out(option_out),
  .presc_clr_out(presc_clr_out), .wdt_clr_out(wdt_clr_out)
);
`default_nettype wire

// ---- verification/bid_core_tb.sv ----
// Self-checking bench: runs a short program through the core.
// Assumes one instruction per four clocks once the run bit is set.
`timescale 1ns/1ps
`default_nettype none
module bid_core_tb;
  import bid_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [8:0]  pmem_addr_out;
  logic [11:0] pmem_data_in;
  logic [4:0]  freg_raddr_out;
  logic [7:0]  freg_rdata_in;
  logic [4:0]  freg_waddr_out;
  logic [7:0]  freg_wdata_out;
  logic        freg_we_out;
  logic [7:0]  port_pin_in = 8'h00;
  logic [7:0]  direction_latch_load_out;
  logic [7:0]  option_out;
  logic        presc_clr_out;
  logic        wdt_clr_out;
  logic        wake_in = 1'b0;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          presc_seen = 0;
  int          wdt_seen = 0;
  logic [12:0] wq [$];
  logic [31:0] rq [$];
  logic [7:0]  pins;
  // Index 9 must be skipped; its write would show up unexpected
  // Index 17 calls 20, which returns into standby at 18; after wake 19 branches to 0x100
  localparam logic [11:0] PROG [21] = '{12'hc0f, 12'h1e8, 12'h089, 12'hf71, 12'h02b,
    12'h36a, 12'h5eb, 12'h2ea, 12'h6cb, 12'h50b, 12'hc5a, 12'h006, 12'h226, 12'h004,
    12'hc37, 12'h002, 12'h2a1, 12'h914, 12'h003, 12'hb00, 12'h8a5};
  always #2 clk_in = ~clk_in;
  bid_core dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pmem_addr_out(pmem_addr_out),
    .pmem_data_in(pmem_data_in), .freg_raddr_out(freg_raddr_out),
    .freg_rdata_in(freg_rdata_in), .freg_waddr_out(freg_waddr_out),
    .freg_wdata_out(freg_wdata_out), .freg_we_out(freg_we_out),
    .port_pin_in(port_pin_in), .direction_latch_load_out(direction_latch_load_out), .option_out(option_out),
    .presc_clr_out(presc_clr_out), .wdt_clr_out(wdt_clr_out), .wake_in(wake_in)
  );
  bid_mem_model mem_u (
    .clk_in(clk_in), .pmem_addr_in(pmem_addr_out), .pmem_data_out(pmem_data_in),
    .freg_raddr_in(freg_raddr_out), .freg_rdata_out(freg_rdata_in),
    .freg_waddr_in(freg_waddr_out), .freg_wdata_in(freg_wdata_out),
    .freg_we_in(freg_we_out)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  always @(posedge clk_in) begin
    if (freg_we_out === 1'b1) begin
      chk("file write", (wq.size() > 0) ? {19'h0, wq.pop_front()} : 32'hx,
          {19'h0, freg_waddr_out, freg_wdata_out});
    end
    if (presc_clr_out === 1'b1) presc_seen++;
    if (wdt_clr_out === 1'b1) wdt_seen++;
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
      chk("bus read", (rq.size() > 0) ? rq.pop_front() : 32'hx, avs_readdata_out);
    end
  end
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h115540ad));
    pins = 8'($urandom());
    repeat (12) @(posedge clk_in);
    rst_n_in    <= 1'b1;
    port_pin_in <= pins;
    foreach (PROG[i]) mem_u.prog[i] = PROG[i];
    mem_u.prog[9'h100] = 12'hb00;
    mem_u.regs[1]  = 8'h7f;
    mem_u.regs[6]  = ~pins;
    mem_u.regs[8]  = 8'h35;
    mem_u.regs[9]  = 8'h80;
    mem_u.regs[10] = 8'h81;
    wq = '{{5'd8, 8'h44}, {5'd11, 8'h00}, {5'd10, 8'h03}, {5'd11, 8'h80},
           {5'd10, 8'h02}, {5'd6, pins}, {5'd1, 8'h80}};
    chk("direction_latch_load reset", {24'h0, DIRECTION_LATCH_LOAD_RST}, {24'h0, direction_latch_load_out});
    @(posedge clk_in);
    bus(1'b1, CSR_CTRL, 32'h1);
    repeat (120) @(posedge clk_in);
    chk("pending writes", 32'h0, wq.size());
    chk("direction_latch_load", 32'h5a, {24'h0, direction_latch_load_out});
    chk("option", 32'h37, {24'h0, option_out});
    chk("prescaler clears", 32'h1, presc_seen);
    chk("watchdog clears", 32'h1, wdt_seen);
    rd(CSR_ACC, 32'ha5);
    rd(CSR_STAT, 32'h31);
    rd(4'h1, 32'h0);
    bus(1'b1, CSR_ACC, 32'hff);
    rd(CSR_ACC, 32'ha5);
    rd(CSR_CTRL, 32'h1);
    // Wake from standby; the branch to 0x100 has a zero literal and must leave zero clear
    wake_in <= 1'b1;
    repeat (24) @(posedge clk_in);
    rd(CSR_STAT, 32'h11);
    chk("pending reads", 32'h0, rq.size());
    end_of_test();
  end
endmodule : bid_core_tb
`default_nettype wire

// ---- verification/bid_mem_model.sv ----
// Program memory and file register space facing the decoder core.
// Assumes the bench preloads both arrays before the core runs.
`timescale 1ns/1ps
`default_nettype none
module bid_mem_model (
  input  wire logic        clk_in,
  input  wire logic [8:0]  pmem_addr_in,
  output logic      [11:0] pmem_data_out,
  input  wire logic [4:0]  freg_raddr_in,
  output logic      [7:0]  freg_rdata_out,
  input  wire logic [4:0]  freg_waddr_in,
  input  wire logic [7:0]  freg_wdata_in,
  input  wire logic        freg_we_in
);
  logic [11:0] prog [512];
  logic [7:0]  regs [32];
  initial begin
    foreach (prog[i]) prog[i] = 12'h000;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  assign pmem_data_out  = prog[pmem_addr_in];
  assign freg_rdata_out = regs[freg_raddr_in];
  // Writes land at the edge that ends the pulse
  always @(posedge clk_in) begin
    if (freg_we_in === 1'b1) begin
      regs[freg_waddr_in] <= freg_wdata_in;
    end
  end
endmodule : bid_mem_model
`default_nettype wire
